// ==== logic/dram_row_refresh_cfg.svh ====
// timing counts, widths and tap positions for the row refresh control
// assumes a single 10 MHz clock; included by the timer, sequencer and control files
//
// Contract
// - every row read once per 2 ms
// - internal mode renews one row per 25 us
// - mode jumper runs timer, else external gate
// - timer tick sets renew request while enabled
// - launch only when reply and block idle
// - launch sets internal flag; drives renew cycle
// - internal renew waits 80 ns before strobe
// - row strobe blocks new launches until end
// - internal renew puts counter on row address
// - answer jumper stops reply during renew
// - reply point in renew clears renew request
// - cycle end clears renew flag and strobe
// - counter advances at tick trailing edge
// - busy bus cycle defers renew to relaunch
// - latch row and refresh flag; force selection
// - external renew reply follows answer jumper
// - bus and renew cycles wait for each other
// - strobe gives four ordered phase points
`ifndef DRAM_ROW_REFRESH_CFG_SVH
`define DRAM_ROW_REFRESH_CFG_SVH

`define CLK_PERIOD_NS      100
`define RENEW_ROWS         64
`define RENEW_LIMIT_MS     2
`define ROW_BITS           6
`define BANK_BITS          3
`define TIMER_PERIOD_NS    25000
`define TIMER_CYCLES       (`TIMER_PERIOD_NS / `CLK_PERIOD_NS)
`define SETTLE_NS          80
`define SETTLE_CYCLES      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TAP_COLUMN         1
`define TAP_COL_STROBE     2
`define TAP_ANSWER         3
`define TAP_END            5
`define PHASE_BITS         4

`endif

// ==== logic/dram_row_refresh_pkg.sv ====
// types shared by the row refresh control modules
// assumes the cfg header is on the include path
`default_nettype none
package dram_row_refresh_pkg;
    typedef enum logic [1:0] {
        cyc_idle,
        cyc_settle,
        cyc_strobe
    } cycle_state_e;
endpackage
`default_nettype wire

// ==== logic/phase_if.sv ====
// carrier between the controller and its phase sequencer
// assumes both ends sit on the same clock
`timescale 1ns/1ns
`default_nettype none
interface phase_if;
    logic start;
    logic column_phase_point;
    logic column_strobe_point;
    logic answer_point;
    logic cycle_end;
    modport seq (input start, output column_phase_point, column_strobe_point, answer_point, cycle_end);
    modport ctl (output start, input column_phase_point, column_strobe_point, answer_point, cycle_end);
endinterface
`default_nettype wire

// ==== logic/renew_timer.sv ====
// free running 25 us renew timer with enable
// assumes synchronous active high reset on the system clock
`include "dram_row_refresh_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module renew_timer (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic timer_enable,
    output logic      renew_timer_tick
);
    localparam logic [7:0] LAST = 8'(`TIMER_CYCLES - 1);
    logic [7:0] count;

    // divider; held at zero while disabled so mode changes start clean
    always_ff @(posedge clk) begin
        if (rst || !timer_enable) begin
            count            <= 8'h00;
            renew_timer_tick <= 1'b0;
        end else begin
            renew_timer_tick <= (count == LAST);
            count            <= (count == LAST) ? 8'h00 : count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== logic/phase_sequencer.sv ====
// clocked replacement for the ramp and comparators
// assumes start stays high from row strobe until cycle end
`include "dram_row_refresh_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module phase_sequencer #(
    parameter logic [3:0] TAP_COLUMN     = 4'(`TAP_COLUMN),
    parameter logic [3:0] TAP_COL_STROBE = 4'(`TAP_COL_STROBE),
    parameter logic [3:0] TAP_ANSWER     = 4'(`TAP_ANSWER),
    parameter logic [3:0] TAP_END        = 4'(`TAP_END)
) (
    input  wire logic clk,
    input  wire logic rst,
    phase_if.seq      ph
);
    logic [`PHASE_BITS-1:0] ramp;

    // ramp runs only while the strobe is held, resets when it drops
    always_ff @(posedge clk) begin
        if (rst || !ph.start || ph.cycle_end) begin
            ramp <= '0;
        end else if (ramp != 4'hF) begin
            ramp <= ramp + 4'h1;
        end
    end

    // ordered points, levels except the two pulses
    always_comb begin
        ph.column_phase_point  = ph.start && (ramp >= TAP_COLUMN);
        ph.column_strobe_point = ph.start && (ramp >= TAP_COL_STROBE);
        ph.answer_point        = ph.start && (ramp == TAP_ANSWER);
        ph.cycle_end           = ph.start && (ramp == TAP_END);
    end
endmodule
`default_nettype wire

// ==== logic/dram_row_refresh_control.sv ====
// refresh control and cycle arbitration for a dynamic memory board
// assumes bus inputs already synchronous to clk; bus lines active low
`include "dram_row_refresh_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dram_row_refresh_control
    import dram_row_refresh_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    renew_mode_jumper,
    input  wire logic                    renew_answer_jumper,
    input  wire logic [`BANK_BITS-1:0]   start_bank,
    input  wire logic                    bsync_n,
    input  wire logic                    bref_n,
    input  wire logic                    bdin_n,
    input  wire logic                    bdout_n,
    input  wire logic                    bwtbt_n,
    input  wire logic [15:0]             bdal_n,
    output logic                         brply_out,
    output logic                         brply_oe_n,
    output logic                         board_selected,
    output logic                         renew_cycle_n,
    output logic                         cycle_block_n,
    output logic                         dram_ras,
    output logic                         dram_cas,
    output logic                         dram_write,
    output logic [`ROW_BITS-1:0]         dram_addr,
    output logic [`ROW_BITS-1:0]         renew_row_count
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [3:0] SETTLE_LAST = 4'(`SETTLE_CYCLES - 1);

    cycle_state_e           state;
    logic [3:0]             settle_count;
    logic                   timer_enable;
    logic                   renew_timer_tick;
    logic                   tick_seen;
    logic                   renew_request;
    logic                   internal_renew_active;
    logic                   outside_renew_seen;
    logic                   latched_outside_renew;
    logic                   answer_flag;
    logic                   row_strobe_active;
    logic                   sync_seen;
    logic                   address_latch;
    logic [15:0]            latched_addr;
    logic                   latched_write;
    logic                   range_hit;
    logic                   selected;
    logic                   read_done;
    logic                   write_done;
    logic                   read_req;
    logic                   write_req;
    logic                   cycle_launch;
    logic                   cycle_is_write;
    logic                   renew_cycle;
    logic                   answer_block;
    logic                   next_answer;
    logic [`ROW_BITS-1:0]   next_addr;

    phase_if ph ();

    // ------------------------------------------------------------
    // mode and timer
    // ------------------------------------------------------------
    // jumper fitted means the board renews itself
    assign timer_enable = renew_mode_jumper;

    renew_timer u_timer (
        .clk              (clk),
        .rst              (rst),
        .timer_enable     (timer_enable),
        .renew_timer_tick (renew_timer_tick)
    );

    phase_sequencer u_phase (
        .clk (clk),
        .rst (rst),
        .ph  (ph)
    );

    // ------------------------------------------------------------
    // renew request flop
    // ------------------------------------------------------------
    // tick sets, reply point of an internal renew clears; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            renew_request <= 1'b0;
        end else if (renew_timer_tick && timer_enable) begin
            renew_request <= 1'b1;
        end else if (ph.answer_point && internal_renew_active) begin
            renew_request <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // row counter
    // ------------------------------------------------------------
    // advance one cycle after the tick, the tick's trailing edge
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_seen <= 1'b0;
        end else begin
            tick_seen <= renew_timer_tick;
        end
    end

    // wraps after 64 rows, so 64 ticks of 25 us cover the array
    always_ff @(posedge clk) begin
        if (rst) begin
            renew_row_count <= '0;
        end else if (tick_seen && !renew_timer_tick) begin
            renew_row_count <= renew_row_count + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    // latch time is the first cycle with sync asserted
    assign address_latch = !bsync_n && !sync_seen;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_seen <= 1'b0;
        end else begin
            sync_seen <= !bsync_n;
        end
    end

    // row address and refresh flag caught together
    always_ff @(posedge clk) begin
        if (rst) begin
            latched_addr       <= 16'h0000;
            latched_write      <= 1'b0;
            outside_renew_seen <= 1'b0;
        end else if (address_latch) begin
            latched_addr       <= ~bdal_n;
            latched_write      <= !bwtbt_n;
            outside_renew_seen <= !bref_n;
        end else if (bsync_n) begin
            outside_renew_seen <= 1'b0;
        end
    end

    // external renew only counts with the mode jumper removed
    assign latched_outside_renew = outside_renew_seen && !renew_mode_jumper;

    // one 4K word bank per board; forced on by an external renew
    assign range_hit = (latched_addr[15:13] == start_bank);
    assign selected  = sync_seen && (range_hit || latched_outside_renew);

    // ------------------------------------------------------------
    // bus cycle requests
    // ------------------------------------------------------------
    // one launch per strobe phase, like the go-inhibit flop
    always_ff @(posedge clk) begin
        if (rst || bsync_n) begin
            read_done  <= 1'b0;
            write_done <= 1'b0;
        end else if (cycle_launch && !renew_request) begin
            read_done  <= read_done || !cycle_is_write;
            write_done <= write_done || cycle_is_write;
        end
    end

    assign read_req  = selected && !latched_write && !bdin_n && !read_done;
    assign write_req = selected && !bdout_n && !write_done;

    // ------------------------------------------------------------
    // launch and arbitration
    // ------------------------------------------------------------
    // nothing starts while a cycle runs or a reply is still up
    assign cycle_launch   = (state == cyc_idle) && !answer_flag
                            && (renew_request || read_req || write_req);
    assign cycle_is_write = write_req && !read_req;

    // a pending renew owns the launch; a bus cycle already running
    // finished first, so the renew simply relaunches afterwards
    always_ff @(posedge clk) begin
        if (rst) begin
            internal_renew_active <= 1'b0;
        end else if (ph.cycle_end) begin
            internal_renew_active <= 1'b0;
        end else if (cycle_launch) begin
            internal_renew_active <= renew_request;
        end
    end

    // ------------------------------------------------------------
    // cycle state
    // ------------------------------------------------------------
    // settle only for internal renews; bus cycles strobe at once
    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= cyc_idle;
            settle_count <= 4'h0;
        end else begin
            case (state)
                cyc_idle: begin
                    settle_count <= 4'h0;
                    if (cycle_launch) begin
                        state <= renew_request ? cyc_settle : cyc_strobe;
                    end
                end
                cyc_settle: begin
                    settle_count <= settle_count + 4'h1;
                    if (settle_count == SETTLE_LAST) begin
                        state <= cyc_strobe;
                    end
                end
                cyc_strobe: begin
                    if (ph.cycle_end) begin
                        state <= cyc_idle;
                    end
                end
                default: begin
                    state <= cyc_idle;
                end
            endcase
        end
    end

    assign row_strobe_active = (state == cyc_strobe);
    assign ph.start          = row_strobe_active;

    // ------------------------------------------------------------
    // reply flop
    // ------------------------------------------------------------
    // renew cycle plus fitted answer jumper keeps the bus quiet
    assign renew_cycle  = internal_renew_active || latched_outside_renew;
    assign answer_block = renew_answer_jumper && renew_cycle;

    always_comb begin
        next_answer = answer_flag;
        if (ph.answer_point && !answer_block && !internal_renew_active
            && (!bdin_n || !bdout_n)) begin
            next_answer = 1'b1;
        end else if (bdin_n && bdout_n) begin
            next_answer = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            answer_flag <= 1'b0;
        end else begin
            answer_flag <= next_answer;
        end
    end

    // ------------------------------------------------------------
    // array address mux
    // ------------------------------------------------------------
    // internal renew: counter on row, zero on column; bus and external renew: latched bits
    always_comb begin
        if (internal_renew_active) begin
            next_addr = ph.column_phase_point ? 6'h00 : renew_row_count;
        end else if (ph.column_phase_point) begin
            next_addr = latched_addr[12:7];
        end else begin
            next_addr = latched_addr[6:1];
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // everything leaves through a flop, one clock behind its cause
    always_ff @(posedge clk) begin
        if (rst) begin
            brply_out      <= 1'b0;
            brply_oe_n     <= 1'b1;
            board_selected <= 1'b0;
            renew_cycle_n  <= 1'b1;
            cycle_block_n  <= 1'b1;
            dram_ras       <= 1'b0;
            dram_cas       <= 1'b0;
            dram_write     <= 1'b0;
            dram_addr      <= '0;
        end else begin
            brply_out      <= 1'b0;
            brply_oe_n     <= !next_answer;
            board_selected <= selected;
            renew_cycle_n  <= !renew_cycle;
            cycle_block_n  <= (state == cyc_idle) && !cycle_launch;
            dram_ras       <= row_strobe_active && !ph.cycle_end;
            dram_cas       <= ph.column_strobe_point && !ph.cycle_end;
            dram_write     <= row_strobe_active && !internal_renew_active && !bdout_n;
            dram_addr      <= next_addr;
        end
    end

endmodule
`default_nettype wire

// ==== dv/dram_row_refresh_control_properties.sv ====
// port assertions for the row refresh control
// assumes one clock domain, bound to the top module
`timescale 1ns/1ns
`default_nettype none
module dram_row_refresh_control_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       renew_mode_jumper,
    input wire logic       renew_answer_jumper,
    input wire logic       bsync_n,
    input wire logic       bref_n,
    input wire logic       brply_oe_n,
    input wire logic       board_selected,
    input wire logic       renew_cycle_n,
    input wire logic       cycle_block_n,
    input wire logic       dram_ras,
    input wire logic       dram_cas,
    input wire logic [5:0] dram_addr,
    input wire logic [5:0] renew_row_count
);
    // ----
    // cycle and reply checks
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_settle_gap: assert property ($fell(renew_cycle_n) && renew_mode_jumper |=> $rose(dram_ras))
        else $error("strobe not after one settle cycle");
    a_strobe_locks: assert property (dram_ras |-> !cycle_block_n)
        else $error("strobe without lockout");
    a_strobe_width: assert property ($rose(dram_ras) |-> dram_ras [*5] ##1 !dram_ras)
        else $error("strobe width wrong");
    a_column_in_strobe: assert property (dram_cas |-> dram_ras)
        else $error("column strobe outside row strobe");
    a_renew_row: assert property ($rose(dram_ras) && !renew_cycle_n && renew_mode_jumper
        |-> dram_addr == renew_row_count)
        else $error("renew row not from counter");
    a_quiet_internal: assert property (!renew_cycle_n && renew_mode_jumper |-> brply_oe_n)
        else $error("reply during internal renew");
    a_quiet_outside: assert property (!renew_cycle_n && !renew_mode_jumper && renew_answer_jumper
        |-> brply_oe_n)
        else $error("reply during silent outside renew");
    a_row_steps: assert property ($changed(renew_row_count)
        |-> renew_row_count == $past(renew_row_count) + 6'h01)
        else $error("row counter skipped");
    a_launch_idle: assert property ($fell(cycle_block_n) |-> $past(brply_oe_n))
        else $error("launch while reply up");
    a_forced_select: assert property ($fell(bsync_n) && !bref_n && !renew_mode_jumper
        |-> ##[1:2] board_selected)
        else $error("outside renew not selected");
endmodule

bind dram_row_refresh_control dram_row_refresh_control_properties i_dram_row_refresh_control_properties (
    .clk(clk), .rst(rst), .renew_mode_jumper(renew_mode_jumper),
    .renew_answer_jumper(renew_answer_jumper), .bsync_n(bsync_n), .bref_n(bref_n),
    .brply_oe_n(brply_oe_n), .board_selected(board_selected), .renew_cycle_n(renew_cycle_n),
    .cycle_block_n(cycle_block_n), .dram_ras(dram_ras), .dram_cas(dram_cas),
    .dram_addr(dram_addr), .renew_row_count(renew_row_count)
);
`default_nettype wire

// ==== dv/bus_master_model.sv ====
// bus master issuing read, write and refresh transfers
// assumes released bus lines are terminated high
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
    input  wire logic   clk,
    input  wire logic   brply_oe_n,
    output logic        bsync_n,
    output logic        bref_n,
    output logic        bdin_n,
    output logic        bdout_n,
    output logic        bwtbt_n,
    output logic [15:0] bdal_n
);
    // idle bus
    initial begin
        {bsync_n, bref_n, bdin_n, bdout_n, bwtbt_n} = 5'h1F;
        bdal_n = 16'hFFFF;
    end

    // no reply in the wait means another board answers
    task automatic transfer(input logic [15:0] addr, input logic rfsh, input logic wr, output logic rep);
        int n;
        n = 0;
        @(posedge clk);
        bref_n  <= ~rfsh;
        bwtbt_n <= ~wr;
        bdal_n  <= ~addr;
        @(posedge clk);
        bsync_n <= 1'b0;
        @(posedge clk);
        bwtbt_n <= 1'b1;
        bdal_n  <= wr ? 16'hA5A5 : 16'hFFFF;
        bdin_n  <= wr;
        bdout_n <= ~wr;
        while (brply_oe_n !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        rep = (brply_oe_n === 1'b0);
        {bdin_n, bdout_n} <= 2'h3;
        bdal_n <= 16'hFFFF;
        @(posedge clk);
        while (brply_oe_n !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        bsync_n <= 1'b1;
        bref_n  <= 1'b1;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_dram_row_refresh_control.sv ====
// testbench for the row refresh control
// assumes the design files and the bus master model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_dram_row_refresh_control;
    logic        clk, rst, renew_mode_jumper, renew_answer_jumper, ras_d;
    logic [2:0]  start_bank;
    logic        bsync_n, bref_n, bdin_n, bdout_n, bwtbt_n;
    logic [15:0] bdal_n;
    logic        brply_out, brply_oe_n, board_selected, renew_cycle_n;
    logic        cycle_block_n, dram_ras, dram_cas, dram_write;
    logic [5:0]  dram_addr, renew_row_count, last_row;
    int          n_mismatch, num_checks, cycles, sel_hits, wr_hits;

    dram_row_refresh_control i_dram_row_refresh_control (
        .clk(clk), .rst(rst), .renew_mode_jumper(renew_mode_jumper),
        .renew_answer_jumper(renew_answer_jumper), .start_bank(start_bank),
        .bsync_n(bsync_n), .bref_n(bref_n), .bdin_n(bdin_n), .bdout_n(bdout_n),
        .bwtbt_n(bwtbt_n), .bdal_n(bdal_n), .brply_out(brply_out), .brply_oe_n(brply_oe_n),
        .board_selected(board_selected), .renew_cycle_n(renew_cycle_n),
        .cycle_block_n(cycle_block_n), .dram_ras(dram_ras), .dram_cas(dram_cas),
        .dram_write(dram_write), .dram_addr(dram_addr), .renew_row_count(renew_row_count)
    );
    bus_master_model i_bus_master_model (
        .clk(clk), .brply_oe_n(brply_oe_n), .bsync_n(bsync_n), .bref_n(bref_n),
        .bdin_n(bdin_n), .bdout_n(bdout_n), .bwtbt_n(bwtbt_n), .bdal_n(bdal_n)
    );

    // ----
    // clock, monitor, hang guard
    // ----
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // row captured at strobe rise; later the column follows
    always @(posedge clk) begin
        cycles <= cycles + 1;
        ras_d  <= dram_ras;
        if (dram_ras === 1'b1 && ras_d !== 1'b1) last_row <= dram_addr;
        if (board_selected === 1'b1) sel_hits <= sel_hits + 1;
        if (dram_write === 1'b1) wr_hits <= wr_hits + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic await_renew(input logic lvl);
        int n;
        n = 0;
        while (renew_cycle_n !== lvl && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_internal();
        int   t0, n;
        logic quiet;
        for (int k = 1; k <= 2; k++) begin
            await_renew(1'b0);
            if (k == 2) check(16'(cycles - t0), 16'h00FA);
            t0 = cycles;
            n = 0;
            quiet = 1'b1;
            while (renew_cycle_n !== 1'b1 && n < 20) begin
                @(posedge clk);
                quiet &= brply_oe_n;
                n++;
            end
            check(16'(last_row), 16'(k));
            check(16'(renew_row_count), 16'(k));
            check(16'(quiet), 16'h0001);
            check(16'(cycle_block_n), 16'h0001);
        end
    endtask
    // read launched just before the tick holds the renew back
    task automatic t_defer();
        int   t0;
        logic rep;
        await_renew(1'b0);
        t0 = cycles;
        repeat (238) @(posedge clk);
        i_bus_master_model.transfer(16'h4010, 1'b0, 1'b0, rep);
        check(16'(rep), 16'h0001);
        await_renew(1'b0);
        check(16'(cycles - t0 > 250), 16'h0001);
        check(16'(cycles - t0 < 280), 16'h0001);
    endtask
    task automatic t_bus();
        logic rep;
        int   s, w;
        w = wr_hits;
        i_bus_master_model.transfer(16'h4010, 1'b0, 1'b1, rep);
        check(16'(rep), 16'h0001);
        check(16'(wr_hits > w), 16'h0001);
        check(16'(brply_out), 16'h0000);
        // let the last selection drain out of the registered output
        repeat (3) @(posedge clk);
        s = sel_hits;
        i_bus_master_model.transfer(16'h8010, 1'b0, 1'b0, rep);
        check(16'(rep), 16'h0000);
        check(16'(sel_hits - s), 16'h0000);
    endtask
    task automatic t_external();
        logic rep, quiet;
        int   s;
        await_renew(1'b0);
        await_renew(1'b1);
        renew_mode_jumper <= 1'b0;
        quiet = 1'b1;
        repeat (300) begin
            @(posedge clk);
            quiet &= renew_cycle_n;
        end
        check(16'(quiet), 16'h0001);
        s = sel_hits;
        i_bus_master_model.transfer(16'h8054, 1'b1, 1'b0, rep);
        check(16'(rep), 16'h0000);
        check(16'(last_row), 16'h002A);
        check(16'(sel_hits > s), 16'h0001);
        renew_answer_jumper <= 1'b0;
        for (int r = 0; r < 64; r++) begin
            i_bus_master_model.transfer(16'h8000 | 16'(r << 1), 1'b1, 1'b0, rep);
            check(16'(rep), 16'h0001);
            check(16'(last_row), 16'(r));
        end
    endtask

    // main sequence
    initial begin
        {rst, renew_mode_jumper, renew_answer_jumper} = 3'h7;
        start_bank = 3'h2;
        cycles = 0;
        sel_hits = 0;
        wr_hits = 0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        check(16'({brply_oe_n, renew_cycle_n, cycle_block_n, dram_ras, renew_row_count}), 16'h0380);
        rst <= 1'b0;
        t_internal();
        t_defer();
        t_bus();
        t_external();
        tally_and_finish();
    end
endmodule
`default_nettype wire
